// [uie_top.sv]
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "uie_cfg.svh"
module uie_top
   import uie_pkg::*;
#(
   parameter int GPIO_W = 8
) (
   input wire logic MCLK_IN,
   input wire logic NRST_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic [7:0] RX_LEVEL_IN,
   input wire logic [7:0] RX_TRIG_IN,
   input wire logic [7:0] TX_LEVEL_IN,
   input wire logic [7:0] TX_TRIG_IN,
   input wire logic TX_SHIFT_EMPTY_IN,
   input wire logic [7:0] RX_DATA_IN,
   input wire logic RX_PUSH_IN,
   input wire logic [2:0] RX_PUSH_ERR_IN,
   input wire logic [2:0] RX_HEAD_ERR_IN,
   input wire logic RX_ANY_ERR_IN,
   input wire logic OVERRUN_IN,
   input wire logic [3:0] MODEM_DELTA_IN,
   input wire logic [3:0] MODEM_LINES_IN,
   input wire logic XON_MATCH_IN,
   input wire logic XOFF_MATCH_IN,
   input wire logic SPECIAL_MATCH_IN,
   input wire logic RTS_IN,
   input wire logic CTS_N_IN,
   input wire logic WAKE_IN,
   input wire logic [GPIO_W-1:0] GPIO_IN,
   input wire logic BIT_TICK_IN,
   input wire logic [3:0] CHAR_BITS_IN,
   output logic INT_OUT,
   output logic RX_READ_OUT,
   output logic TX_WRITE_OUT,
   output logic [7:0] TX_DATA_OUT,
   output logic MSR_READ_OUT,
   output logic SLEEP_EN_OUT,
   output logic FIFO_EN_OUT
);
   // ==========================================
   // reset release
   logic rst_meta;
   logic rst_n;
   uie_state_s st;
   uie_state_s next_st;
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================
   // combinational helpers
   logic fifo_en;
   logic rd_take;
   logic wr_take;
   logic [7:0] addr;
   logic rx_any;
   logic rx_int;
   logic tx_cond;
   logic modem_int;
   logic [7:0] tout_lim;
   logic [7:0] gpio_lvl;
   logic [5:0] code_lo;
   logic [7:0] line_stat;
   always_comb begin
      fifo_en = st.ctrl[`UIE_CTRL_FIFO];
      addr = HADDR_IN[7:0];
      rd_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
      wr_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN;
      gpio_lvl = (st.gpio_sync ^ st.ginv);
      rx_any = (RX_LEVEL_IN != 8'h00);
      rx_int = st.mask[0] && (fifo_en ? (RX_LEVEL_IN >= RX_TRIG_IN) : rx_any);
      tx_cond = fifo_en ? ((TX_LEVEL_IN < TX_TRIG_IN) || (TX_LEVEL_IN == 8'h00))
                        : (TX_LEVEL_IN == 8'h00);
      modem_int = st.mask[3] && (MODEM_DELTA_IN != 4'h0);
      tout_lim = 8'(`UIE_TOUT_CHARS * CHAR_BITS_IN + `UIE_TOUT_BITS);
      line_stat = {RX_ANY_ERR_IN, (TX_LEVEL_IN == 8'h00) && TX_SHIFT_EMPTY_IN,
                   TX_LEVEL_IN == 8'h00, RX_HEAD_ERR_IN, st.overrun, rx_any};
      if (st.line_int) begin
         code_lo = `UIE_CODE_LINE;
      end else if (st.tout_int) begin
         code_lo = `UIE_CODE_TOUT;
      end else if (rx_int) begin
         code_lo = `UIE_CODE_RECEIVE_READY_EVENT;
      end else if (st.tx_int) begin
         code_lo = `UIE_CODE_TRANSMIT_READY_EVENT;
      end else if (modem_int) begin
         code_lo = `UIE_CODE_MODEM;
      end else if (st.match_int) begin
         code_lo = `UIE_CODE_MATCH;
      end else if (st.flow_int) begin
         code_lo = `UIE_CODE_FLOW;
      end else begin
         code_lo = `UIE_CODE_NONE;
      end
   end

   // ==========================================
   // next state
   always_comb begin
      next_st = st;
      next_st.cts_prev = st.cts_sync;
      next_st.rx_read = 1'b0;
      next_st.tx_write = 1'b0;
      next_st.msr_read = 1'b0;
      next_st.gpio_meta = 8'(GPIO_IN);
      next_st.gpio_sync = st.gpio_meta;
      next_st.cts_meta = CTS_N_IN;
      next_st.cts_sync = st.cts_meta;
      next_st.rts_prev = RTS_IN;
      next_st.head_err_prev = (RX_HEAD_ERR_IN != 3'h0);
      next_st.tx_cond_prev = tx_cond;
      next_st.gpio_act = ((gpio_lvl & st.gen) != 8'h00);
      next_st.wr_pend = wr_take;
      next_st.wr_addr = addr;

      // read side effects clear first, so any set below wins, except the time-out set, which a data read blocks
      if (rd_take) begin
         unique case (addr)
            `UIE_OFS_CODE: begin
               if (code_lo == `UIE_CODE_TRANSMIT_READY_EVENT) begin
                  next_st.tx_int = 1'b0;
               end
               if (code_lo == `UIE_CODE_MATCH) begin
                  next_st.match_int = 1'b0;
                  next_st.special = 1'b0;
               end
               next_st.wake_int = 1'b0;
            end
            `UIE_OFS_LINE: begin
               next_st.line_int = 1'b0;
               next_st.overrun = 1'b0;
            end
            `UIE_OFS_MODEM: begin
               next_st.flow_int = 1'b0;
               next_st.msr_read = 1'b1;
            end
            `UIE_OFS_DATA: begin
               next_st.tout_int = 1'b0;
               next_st.rx_read = 1'b1;
            end
            `UIE_OFS_GLVL: begin
               next_st.gpio_int = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // special clears on next plain character
      if (RX_PUSH_IN && st.special && !SPECIAL_MATCH_IN) begin
         next_st.special = 1'b0;
         next_st.match_int = 1'b0;
      end

      // write data phase
      if (st.wr_pend) begin
         unique case (st.wr_addr)
            `UIE_OFS_MASK: begin
               if (st.ctrl[`UIE_CTRL_UNLOCK]) begin
                  next_st.mask = HWDATA_IN[7:0];
               end else begin
                  next_st.mask = (HWDATA_IN[7:0] & `UIE_MASK_LOCKED)
                                 | (st.mask & ~`UIE_MASK_LOCKED);
               end
            end
            `UIE_OFS_DATA: begin
               next_st.tx_int = 1'b0;
               next_st.tx_write = 1'b1;
               next_st.tx_data = HWDATA_IN[7:0];
            end
            `UIE_OFS_CTRL: begin
               next_st.ctrl = HWDATA_IN[6:0];
            end
            `UIE_OFS_GINV: begin
               next_st.ginv = HWDATA_IN[7:0];
            end
            `UIE_OFS_GEN: begin
               next_st.gen = HWDATA_IN[7:0];
            end
            default: begin
            end
         endcase
      end

      // rising tx condition, or enabled while already empty
      if (tx_cond && ((st.mask[1] && !st.tx_cond_prev) || (next_st.mask[1] && !st.mask[1]))) begin
         next_st.tx_int = 1'b1;
      end
      // mask off drops a pending request
      if (!next_st.mask[1]) begin
         next_st.tx_int = 1'b0;
      end

      // overrun at once, errors at head or entry
      if (OVERRUN_IN) begin
         next_st.overrun = 1'b1;
      end
      if (st.mask[2]) begin
         if (OVERRUN_IN) begin
            next_st.line_int = 1'b1;
         end
         if (st.ctrl[`UIE_CTRL_ERRIN]) begin
            if (RX_PUSH_IN && RX_PUSH_ERR_IN != 3'h0) begin
               next_st.line_int = 1'b1;
            end
         end else if (RX_HEAD_ERR_IN != 3'h0 && !st.head_err_prev) begin
            next_st.line_int = 1'b1;
         end
      end

      // timer runs with data, restarts on traffic
      if (!rx_any || RX_PUSH_IN || (rd_take && addr == `UIE_OFS_DATA)) begin
         next_st.tout_cnt = 8'h00;
      end else if (BIT_TICK_IN && st.tout_cnt < tout_lim) begin
         next_st.tout_cnt = st.tout_cnt + 8'h01;
      end
      if (fifo_en && st.mask[0] && rx_any && st.tout_cnt == tout_lim
          && !(rd_take && addr == `UIE_OFS_DATA)) begin
         next_st.tout_int = 1'b1;
      end

      if (st.mask[5] && (XON_MATCH_IN || XOFF_MATCH_IN || SPECIAL_MATCH_IN)) begin
         next_st.match_int = 1'b1;
         next_st.special = SPECIAL_MATCH_IN;
      end
      if ((st.mask[6] && st.ctrl[`UIE_CTRL_ARTS] && RTS_IN && !st.rts_prev)
          || (st.mask[7] && st.ctrl[`UIE_CTRL_ACTS] && st.cts_sync && !st.cts_prev)) begin
         next_st.flow_int = 1'b1;
      end
      if (WAKE_IN && st.ctrl[`UIE_CTRL_WAKE]) begin
         next_st.wake_int = 1'b1;
      end
      if (next_st.gpio_act && !st.gpio_act) begin
         next_st.gpio_int = 1'b1;
      end

      next_st.code = {fifo_en, fifo_en ^ st.gpio_int, code_lo};
      // wake and gpio raise the line even with no mask bits set
      next_st.irq = !code_lo[0] || st.wake_int || st.gpio_int;

      // registered read data, valid in the data phase
      next_st.rdata = 32'h0000_0000;
      if (rd_take) begin
         unique case (addr)
            `UIE_OFS_MASK: next_st.rdata[7:0] = st.mask;
            `UIE_OFS_CODE: next_st.rdata[7:0] = {fifo_en, fifo_en ^ st.gpio_int, code_lo};
            `UIE_OFS_LINE: next_st.rdata[7:0] = line_stat;
            `UIE_OFS_MODEM: next_st.rdata[7:0] = {MODEM_LINES_IN, MODEM_DELTA_IN};
            `UIE_OFS_DATA: next_st.rdata[7:0] = RX_DATA_IN;
            `UIE_OFS_CTRL: next_st.rdata[6:0] = st.ctrl;
            `UIE_OFS_GINV: next_st.rdata[7:0] = st.ginv;
            `UIE_OFS_GEN: next_st.rdata[7:0] = st.gen;
            `UIE_OFS_GLVL: next_st.rdata[7:0] = gpio_lvl;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.mask <= `UIE_RST_BYTE;
         st.ginv <= `UIE_RST_BYTE;
         st.gen <= `UIE_RST_BYTE;
         // cts flops start high so no false rising edge follows reset
         st.cts_meta <= 1'b1;
         st.cts_sync <= 1'b1;
         st.cts_prev <= 1'b1;
         st.tx_cond_prev <= 1'b1;
         st.code <= {2'b00, `UIE_CODE_NONE};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // outputs; zero-wait slave, always okay
   always_comb begin
      HRDATA_OUT = st.rdata;
      HREADYOUT_OUT = rst_n;
      HRESP_OUT = 1'b0;
      INT_OUT = st.irq;
      RX_READ_OUT = st.rx_read;
      TX_WRITE_OUT = st.tx_write;
      TX_DATA_OUT = st.tx_data;
      MSR_READ_OUT = st.msr_read;
      SLEEP_EN_OUT = st.mask[4];
      FIFO_EN_OUT = st.ctrl[`UIE_CTRL_FIFO];
   end

   // ==========================================
   // checks
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!rst_n);
   chk_rx_trigger: assert property (!st.line_int && !st.tout_int && fifo_en
      && st.mask[0] && RX_LEVEL_IN >= RX_TRIG_IN |=> st.code[5:0] == `UIE_CODE_RECEIVE_READY_EVENT)
      else $error("rx trigger code missing");
   chk_mask_lock: assert property (st.wr_pend && st.wr_addr == `UIE_OFS_MASK
      && !st.ctrl[`UIE_CTRL_UNLOCK] |=> st.mask[7:4] == $past(st.mask[7:4]))
      else $error("upper mask bits changed while locked");
   // line read clears unless a new error lands
   chk_line_clear: assert property (rd_take && addr == `UIE_OFS_LINE && !OVERRUN_IN
      && !RX_PUSH_IN && (RX_HEAD_ERR_IN == 3'h0 || st.head_err_prev) |=> !st.line_int)
      else $error("line interrupt not cleared");
   // modem read clears flow unless a new edge lands
   chk_flow_clear: assert property (rd_take && addr == `UIE_OFS_MODEM
      && !(RTS_IN && !st.rts_prev) && !(st.cts_sync && !st.cts_prev) |=> !st.flow_int)
      else $error("flow flag not cleared");
   chk_line_first: assert property (st.line_int |=> st.code[5:0] == `UIE_CODE_LINE)
      else $error("line status not top priority");
   chk_idle_code: assert property (st.code[0] |-> st.code[5:1] == 5'h00)
      else $error("bad idle code");
   chk_fifo_bit: assert property ($rose(fifo_en) |=> st.code[7])
      else $error("fifo bit wrong");
   chk_tout_set: assert property (fifo_en && st.mask[0] && rx_any && !RX_PUSH_IN
      && !rd_take && st.tout_cnt == tout_lim
      |=> st.tout_int ##1 (st.code[5:0] == `UIE_CODE_TOUT || st.line_int))
      else $error("time-out not raised");
   chk_overrun: assert property (OVERRUN_IN && st.mask[2] |=> st.line_int ##1 INT_OUT)
      else $error("overrun not raised");
   // enabling while empty raises tx ready
   chk_tx_enable: assert property (!st.mask[1] && next_st.mask[1] && tx_cond
      |=> st.tx_int) else $error("tx ready not raised on enable");
endmodule // uie_top

// [uie_cfg.svh]
`ifndef UIE_CFG_SVH
`define UIE_CFG_SVH
// ==========================================
// register byte offsets
`define UIE_OFS_MASK 8'h00
`define UIE_OFS_CODE 8'h04
`define UIE_OFS_LINE 8'h08
`define UIE_OFS_MODEM 8'h0C
`define UIE_OFS_DATA 8'h10
`define UIE_OFS_CTRL 8'h14
`define UIE_OFS_GINV 8'h18
`define UIE_OFS_GEN 8'h1C
`define UIE_OFS_GLVL 8'h20
// ==========================================
// fields and codes
`define UIE_CTRL_FIFO 0
`define UIE_CTRL_UNLOCK 1
`define UIE_CTRL_ARTS 2
`define UIE_CTRL_ACTS 3
`define UIE_CTRL_ERRIN 4
`define UIE_CTRL_WAKE 5
`define UIE_CTRL_SLEEP 6
`define UIE_MASK_LOCKED 8'h0F
`define UIE_RST_BYTE 8'h00
`define UIE_CODE_LINE 6'h06
`define UIE_CODE_TOUT 6'h0C
`define UIE_CODE_RECEIVE_READY_EVENT 6'h04
`define UIE_CODE_TRANSMIT_READY_EVENT 6'h02
`define UIE_CODE_MODEM 6'h00
`define UIE_CODE_MATCH 6'h10
`define UIE_CODE_FLOW 6'h20
`define UIE_CODE_NONE 6'h01
// ==========================================
// time-out in characters plus bits
`define UIE_TOUT_CHARS 4
`define UIE_TOUT_BITS 12
`endif

// [uie_pkg.sv]
package uie_pkg;
   // ==========================================
   // all flip-flops of the top module but the two reset release flops
   typedef struct packed {
      logic cts_prev;
      logic [7:0] mask;
      logic [6:0] ctrl;
      logic [7:0] ginv;
      logic [7:0] gen;
      logic [7:0] gpio_meta;
      logic [7:0] gpio_sync;
      logic gpio_act;
      logic cts_meta;
      logic cts_sync;
      logic rts_prev;
      logic head_err_prev;
      logic tx_cond_prev;
      logic overrun;
      logic line_int;
      logic tx_int;
      logic tout_int;
      logic match_int;
      logic special;
      logic flow_int;
      logic wake_int;
      logic gpio_int;
      logic [7:0] tout_cnt;
      logic [7:0] code;
      logic irq;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic rx_read;
      logic tx_write;
      logic [7:0] tx_data;
      logic msr_read;
   } uie_state_s;
endpackage

// [uie_host.sv]
`timescale 1ns/1ns
// ==========================================
// host model: single word ahb-lite transfers
module uie_host (
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [31:0] hwdata_out
);
   initial begin
      {hsel_out, haddr_out, htrans_out, hwrite_out, hwdata_out} = '0;
   end
   // waits are bounded: ok low means 50 or more wait cycles in all
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic ok);
      int n;
      n = 0;
      @(posedge clk_in);
      hsel_out <= 1'b1;
      htrans_out <= 2'h2;
      haddr_out <= {24'h0, a};
      hwrite_out <= wr;
      @(posedge clk_in);
      while (hready_in !== 1'b1 && n < 50) begin
         @(posedge clk_in);
         n++;
      end
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      @(posedge clk_in);
      while (hready_in !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         n++;
      end
      rd = hrdata_in;
      ok = n < 50;
   endtask
endmodule // uie_host

// [uie_interrupt_enable_status_test.sv]
`timescale 1ns/1ns
`include "uie_cfg.svh"
module uie_interrupt_enable_status_test;
   logic clk, rst_n, hsel, hwrite, hready, hresp, int_o, sleep_en, fifo_en, tx_sh, rts, cts_n;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [7:0] rx_lvl, rx_trig, tx_lvl, rx_data, tx_data, gpio;
   logic [2:0] hd_err;
   logic any_err, rx_rd_o, tx_wr_o, msr_rd_o;
   int n_rx_rd, n_tx_wr, n_msr_rd;
   // pulses: xon, xoff, special, overrun, wake, push, bit tick
   logic [6:0] pl;
   logic [3:0] mdelta, mlines, cbits;
   int n_mismatch, comparisons;
   localparam logic [7:0] msk = `UIE_OFS_MASK, cod = `UIE_OFS_CODE, lin = `UIE_OFS_LINE;
   localparam logic [7:0] mdm = `UIE_OFS_MODEM, dat = `UIE_OFS_DATA, ctl = `UIE_OFS_CTRL;
   localparam logic [7:0] giv = `UIE_OFS_GINV, gpen = `UIE_OFS_GEN, glv = `UIE_OFS_GLVL;
   localparam int tout = `UIE_TOUT_CHARS * 8 + `UIE_TOUT_BITS;
   uie_host h (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
   uie_top #(.GPIO_W(8)) dut (
      .MCLK_IN(clk), .NRST_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .RX_LEVEL_IN(rx_lvl), .RX_TRIG_IN(rx_trig), .TX_LEVEL_IN(tx_lvl), .TX_TRIG_IN(8'h01),
      .TX_SHIFT_EMPTY_IN(tx_sh), .RX_DATA_IN(rx_data), .RX_PUSH_IN(pl[5]),
      .RX_PUSH_ERR_IN(hd_err), .RX_HEAD_ERR_IN(hd_err), .RX_ANY_ERR_IN(any_err),
      .OVERRUN_IN(pl[3]),
      .MODEM_DELTA_IN(mdelta), .MODEM_LINES_IN(mlines), .XON_MATCH_IN(pl[0]),
      .XOFF_MATCH_IN(pl[1]), .SPECIAL_MATCH_IN(pl[2]), .RTS_IN(rts), .CTS_N_IN(cts_n),
      .WAKE_IN(pl[4]), .GPIO_IN(gpio), .BIT_TICK_IN(pl[6]), .CHAR_BITS_IN(cbits),
      .INT_OUT(int_o), .RX_READ_OUT(rx_rd_o), .TX_WRITE_OUT(tx_wr_o), .TX_DATA_OUT(tx_data),
      .MSR_READ_OUT(msr_rd_o), .SLEEP_EN_OUT(sleep_en), .FIFO_EN_OUT(fifo_en));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // one-cycle strobes are counted at the edge that ends them
   always @(posedge clk) begin
      if (rx_rd_o === 1'b1) n_rx_rd <= n_rx_rd + 1;
      if (tx_wr_o === 1'b1) n_tx_wr <= n_tx_wr + 1;
      if (msr_rd_o === 1'b1) n_msr_rd <= n_msr_rd + 1;
   end
   task automatic give_verdict;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic bad(input string s);
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, s);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      logic ok;
      h.xfer(wr, a, wd, rd, ok);
      if (!ok) begin
         bad("bus stuck");
         give_verdict;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      comparisons++;
      if (r !== e || hresp !== 1'b0) bad($sformatf("read %h gave %h", a, r));
   endtask
   task automatic see_int(input logic e);
      comparisons++;
      if (int_o !== e) bad("interrupt line");
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      pl[k] <= 1'b1;
      @(posedge clk);
      pl <= '0;
   endtask
   task automatic t_reset;
      rd(msk, 32'h00); // mask default
      rd(cod, 32'h01); // idle code
      see_int(1'b0); // nothing pending
   endtask
   task automatic t_lock;
      wr(msk, 32'hF0);
      rd(msk, 32'h00); // locked bits
      wr(ctl, 32'h02);
      wr(msk, 32'hF0);
      rd(msk, 32'hF0); // unlocked bits
      comparisons++;
      if (sleep_en !== 1'b1) bad("sleep enable"); // sleep bit
      wr(msk, 32'h00);
      wr(ctl, 32'h00);
   endtask
   task automatic t_tx;
      wr(msk, 32'h02);
      cyc(3);
      see_int(1'b1); // fires when already empty
      rd(cod, 32'h02); // transmit code
      rd(cod, 32'h01); // status read clears
      tx_lvl <= 8'h01;
      cyc(3);
      tx_lvl <= 8'h00;
      cyc(3);
      see_int(1'b1); // holding empties
      wr(dat, 32'h3C);
      cyc(3);
      see_int(1'b0); // write clears
      comparisons++;
      if (tx_data !== 8'h3C) bad("transmit byte"); // data passed on
      wr(msk, 32'h00);
   endtask
   task automatic t_rx;
      wr(ctl, 32'h01);
      rx_lvl <= 8'h04;
      pulse(5);
      cyc(3);
      comparisons++;
      if (fifo_en !== 1'b1) bad("fifo enable"); // fifo enable output
      rd(cod, 32'hC1); // polled mode
      see_int(1'b0); // no interrupt
      wr(msk, 32'h05);
      cyc(3);
      rd(cod, 32'hC4); // trigger reached
      pulse(3);
      cyc(3);
      rd(cod, 32'hC6); // overrun ranks first
      rd(lin, 32'h63); // line status bits
      rd(cod, 32'hC4); // queued source shown
      hd_err <= 3'h2;
      any_err <= 1'b1;
      tx_sh <= 1'b0;
      cyc(3);
      rd(cod, 32'hC6); // error at read position
      rd(lin, 32'hA9); // error type and empties
      wr(ctl, 32'h11);
      pulse(5);
      cyc(2);
      rd(cod, 32'hC6); // error on fifo entry
      rd(lin, 32'hA9); // line read clears
      {hd_err, any_err, tx_sh} <= {3'h0, 1'b0, 1'b1};
      wr(ctl, 32'h01);
      rx_lvl <= 8'h03;
      cyc(3);
      rd(cod, 32'hC1); // below trigger
      wr(ctl, 32'h00);
      rx_lvl <= 8'h01;
      cyc(3);
      rd(cod, 32'h04); // holding full
      rx_lvl <= 8'h00;
      wr(msk, 32'h00);
   endtask
   task automatic t_modem;
      wr(msk, 32'h08);
      mdelta <= 4'h2;
      cyc(3);
      rd(cod, 32'h00); // modem code
      rd(mdm, 32'hA2); // lines and changes
      mdelta <= 4'h0;
      cyc(3);
      rd(cod, 32'h01); // delta drop clears
      wr(msk, 32'h00);
   endtask
   task automatic t_match;
      wr(ctl, 32'h02);
      wr(msk, 32'h20);
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         cyc(2);
         rd(cod, 32'h10); // match code
         rd(cod, 32'h01); // status read clears
      end
      pulse(2);
      pulse(5);
      cyc(2);
      rd(cod, 32'h01); // next character clears
      wr(msk, 32'h00);
   endtask
   task automatic t_flow;
      wr(ctl, 32'h06);
      wr(msk, 32'h40);
      rts <= 1'b1;
      cyc(3);
      rd(cod, 32'h20); // rts rise
      rd(cod, 32'h20); // status read keeps it
      rd(mdm, 32'hA0);
      rd(cod, 32'h01); // modem read clears
      rts <= 1'b0;
      wr(ctl, 32'h0A);
      wr(msk, 32'h80);
      cts_n <= 1'b1;
      cyc(4);
      rd(cod, 32'h20); // cts rise
      rd(mdm, 32'hA0);
      rd(cod, 32'h01); // modem read clears
      wr(msk, 32'h00);
      wr(ctl, 32'h00);
   endtask
   task automatic t_gpio;
      wr(gpen, 32'h01);
      gpio <= 8'h01;
      cyc(5);
      see_int(1'b1); // input asserted
      rd(cod, 32'h41); // bit 6 flags it
      rd(glv, 32'h01); // level read
      rd(cod, 32'h01); // level read clears
      wr(giv, 32'h01);
      wr(ctl, 32'h01);
      gpio <= 8'h00;
      cyc(4);
      rd(cod, 32'h81); // inverted, fifo on
      rd(glv, 32'h01); // inverted level read
      rd(cod, 32'hC1); // bit 6 follows bit 7
      wr(ctl, 32'h00);
      wr(gpen, 32'h00);
   endtask
   task automatic t_wake;
      wr(ctl, 32'h20);
      pulse(4);
      cyc(2);
      see_int(1'b1); // wake raises line
      rd(cod, 32'h01); // wake has no code of its own
      cyc(2);
      see_int(1'b0); // status read clears
      wr(ctl, 32'h00);
   endtask
   task automatic t_tout;
      wr(ctl, 32'h01);
      wr(msk, 32'h01);
      rx_trig <= 8'h08;
      rx_lvl <= 8'h01;
      pulse(5);
      repeat (tout - 4) pulse(6);
      rd(cod, 32'hC1); // not yet expired
      repeat (8) pulse(6);
      rd(cod, 32'hCC); // time-out code
      rd(dat, 32'h5A); // holding read
      rd(cod, 32'hC1); // read clears
      comparisons++;
      if (n_rx_rd != 1 || n_tx_wr != 1 || n_msr_rd != 3) bad("side strobes");
      rx_lvl <= 8'h00;
      wr(msk, 32'h00);
      wr(ctl, 32'h00);
   endtask
   initial begin
      {rst_n, rts, cts_n, pl, mdelta, rx_lvl, tx_lvl, gpio, n_mismatch, comparisons} = '0;
      {tx_sh, mlines, cbits, rx_trig, rx_data} = {1'b1, 4'hA, 4'h8, 8'h04, 8'h5A};
      {hd_err, any_err} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      t_reset;
      t_lock;
      t_tx;
      t_rx;
      t_modem;
      t_match;
      t_flow;
      t_gpio;
      t_wake;
      t_tout;
      give_verdict;
   end
   // a hang ends here as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      bad("timeout");
      give_verdict;
   end
endmodule // uie_interrupt_enable_status_test
